// >>> core/cwrc_pkg.sv
// Constants for the clock watchdog and reset control block
package cwrc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CWRC_ADDR_IDENTITY = 8'h08;
  localparam logic [7:0] CWRC_ADDR_CONTROL = 8'h09;

  // ----------------------------------------------------------------
  // Control byte fields
  // ----------------------------------------------------------------
  localparam int CWRC_BIT_PCI_DRIVE = 6;
  localparam int CWRC_BIT_RST_TIMEOUT = 4;
  localparam int CWRC_BIT_RST_FREQ = 3;
  localparam int CWRC_BIT_TIMEOUT_FLAG = 2;
  localparam int CWRC_BIT_RUN = 1;
  localparam logic [7:0] CWRC_CONTROL_RESET = 8'h00;
  localparam logic [7:0] CWRC_READ_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // Identity byte layout
  // ----------------------------------------------------------------
  localparam int CWRC_REV_LSB = 4;
  localparam int CWRC_CODE_WIDTH = 4;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CWRC_CLK_MHZ = 40;
  localparam int CWRC_UNIT_SHORT_US = 150000;
  localparam int CWRC_UNIT_LONG_US = 2500000;
  localparam int CWRC_SHORT_CYCLES = CWRC_UNIT_SHORT_US * CWRC_CLK_MHZ;
  localparam int CWRC_LONG_CYCLES = CWRC_UNIT_LONG_US * CWRC_CLK_MHZ;
  localparam int CWRC_TICK_WIDTH = 27;
  localparam int CWRC_COUNT_WIDTH = 5;
  localparam int CWRC_RESET_PULSE_CYCLES = 16;

  // ----------------------------------------------------------------
  // Watchdog states, Gray coded along stop, wait, count, locked
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CWRC_WD_STOPPED = 2'h0,
    CWRC_WD_WAIT = 2'h1,
    CWRC_WD_COUNT = 2'h3,
    CWRC_WD_LOCKED = 2'h2
  } cwrc_wd_state_type;

endpackage : cwrc_pkg

// >>> core/cwrc_pulse.sv
// Fixed-length reset pulse generator
`timescale 1ns/1ps
module cwrc_pulse #(
  parameter int PULSE_CYCLES = 16
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic trigger_in,
  output logic pulse_out
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  generate
    if (PULSE_CYCLES < 1 || PULSE_CYCLES > 255) begin : g_bad_len
      $error("cwrc_pulse: PULSE_CYCLES out of range");
    end
  endgenerate

  localparam logic [7:0] LAST = 8'(PULSE_CYCLES - 1);

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  logic [7:0] left_q;
  logic [7:0] left_d;
  logic busy_q;
  logic busy_d;
  wire start = trigger_in & ~busy_q;
  wire done = busy_q & (left_q == 8'h00);

  // Triggers during a pulse merge into it, so pulses never overlap
  assign busy_d = start | (busy_q & ~done);
  assign left_d = start ? LAST : (busy_q ? left_q - 8'h01 : left_q);

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_q <= 1'b0;
      left_q <= 8'h00;
    end else begin
      busy_q <= busy_d;
      left_q <= left_d;
    end
  end

  assign pulse_out = busy_q;

endmodule : cwrc_pulse

// >>> core/cwrc_top.sv
// Watchdog, recovery lock and system reset control
`timescale 1ns/1ps
module cwrc_top
  import cwrc_pkg::*;
#(
  parameter int SHORT_CYCLES = CWRC_SHORT_CYCLES,
  parameter int LONG_CYCLES = CWRC_LONG_CYCLES,
  parameter int PULSE_CYCLES = CWRC_RESET_PULSE_CYCLES,
  parameter logic [3:0] REV_CODE = 4'h3, // Arbitrary value
  parameter logic [3:0] MAKER_CODE = 4'h5 // Arbitrary value
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic [4:0] timeout_count_in,
  input wire logic prescale_long_in,
  input wire logic recovery_source_select_in,
  input wire logic freq_write_in,
  input wire logic freq_change_in,
  output logic freq_write_accept_out,
  output logic recovery_load_out,
  output logic recovery_use_nm_out,
  output logic recovery_mode_out,
  output logic pci_drive_boost_out,
  output logic sys_reset_out
);

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  localparam int TW = CWRC_TICK_WIDTH;
  generate
    if (SHORT_CYCLES < 1 || SHORT_CYCLES >= (1 << TW)) begin : g_bad_short
      $error("cwrc_top: SHORT_CYCLES out of range");
    end
    if (LONG_CYCLES < 1 || LONG_CYCLES >= (1 << TW)) begin : g_bad_long
      $error("cwrc_top: LONG_CYCLES out of range");
    end
  endgenerate

  localparam logic [TW-1:0] SHORT_LAST = TW'(SHORT_CYCLES - 1);
  localparam logic [TW-1:0] LONG_LAST = TW'(LONG_CYCLES - 1);
  localparam int CW = CWRC_COUNT_WIDTH;
  localparam logic [CW-1:0] COUNT_ONE = 5'h01;
  localparam logic [CW-1:0] COUNT_ZERO = 5'h00;
  localparam logic [TW-1:0] TICK_ZERO = '0;
  localparam logic [TW-1:0] TICK_ONE = TW'(1);

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  wire hit_identity = reg_addr_in == CWRC_ADDR_IDENTITY;
  wire hit_control = reg_addr_in == CWRC_ADDR_CONTROL;
  wire wr_control = reg_wr_in & hit_control;
  wire wr_run = reg_wdata_in[CWRC_BIT_RUN];
  wire wr_clear_flag = wr_control & reg_wdata_in[CWRC_BIT_TIMEOUT_FLAG];

  // ----------------------------------------------------------------
  // Control bits
  // ----------------------------------------------------------------
  logic pci_drive_q;
  logic pci_drive_d;
  logic rst_timeout_en_q;
  logic rst_timeout_en_d;
  logic rst_freq_en_q;
  logic rst_freq_en_d;
  logic run_q;
  logic run_d;
  logic flag_q;
  logic flag_d;

  // Reserved bits have no storage at all
  assign pci_drive_d = wr_control ? reg_wdata_in[CWRC_BIT_PCI_DRIVE] : pci_drive_q;
  assign rst_timeout_en_d = wr_control ? reg_wdata_in[CWRC_BIT_RST_TIMEOUT] : rst_timeout_en_q;
  assign rst_freq_en_d = wr_control ? reg_wdata_in[CWRC_BIT_RST_FREQ] : rst_freq_en_q;
  assign run_d = wr_control ? wr_run : run_q;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pci_drive_q <= CWRC_CONTROL_RESET[CWRC_BIT_PCI_DRIVE];
      rst_timeout_en_q <= CWRC_CONTROL_RESET[CWRC_BIT_RST_TIMEOUT];
      rst_freq_en_q <= CWRC_CONTROL_RESET[CWRC_BIT_RST_FREQ];
      run_q <= CWRC_CONTROL_RESET[CWRC_BIT_RUN];
      flag_q <= CWRC_CONTROL_RESET[CWRC_BIT_TIMEOUT_FLAG];
    end else begin
      pci_drive_q <= pci_drive_d;
      rst_timeout_en_q <= rst_timeout_en_d;
      rst_freq_en_q <= rst_freq_en_d;
      run_q <= run_d;
      flag_q <= flag_d;
    end
  end

  // ----------------------------------------------------------------
  // Watchdog state machine
  // ----------------------------------------------------------------
  cwrc_wd_state_type state_q;
  cwrc_wd_state_type state_d;
  logic [TW-1:0] tick_q;
  logic [TW-1:0] tick_d;
  logic [CW-1:0] count_q;
  logic [CW-1:0] count_d;
  logic expire;

  wire run_next = run_d;
  wire unit_done = tick_q == TICK_ZERO;
  wire [TW-1:0] unit_last = prescale_long_in ? LONG_LAST : SHORT_LAST;
  wire last_unit = (count_q == COUNT_ONE) | (count_q == COUNT_ZERO);

  // Expiry wins over a same-cycle clear of the flag
  assign flag_d = expire | (flag_q & ~wr_clear_flag);

  always_comb begin
    state_d = state_q;
    expire = 1'b0;
    case (state_q)
      CWRC_WD_STOPPED: begin
        if (run_next) begin
          state_d = CWRC_WD_WAIT;
        end
      end
      CWRC_WD_WAIT: begin
        if (!run_next) begin
          state_d = CWRC_WD_STOPPED;
        end else if (freq_change_in) begin
          state_d = CWRC_WD_COUNT;
        end
      end
      CWRC_WD_COUNT: begin
        if (!run_next) begin
          state_d = CWRC_WD_STOPPED;
        end else if (unit_done && last_unit) begin
          expire = 1'b1;
          state_d = CWRC_WD_LOCKED;
        end
      end
      CWRC_WD_LOCKED: begin
        // Only a cleared run bit unlocks; a stray change cannot
        if (!run_next) begin
          state_d = CWRC_WD_STOPPED;
        end
      end
      default: begin
        state_d = CWRC_WD_STOPPED;
      end
    endcase
  end

  // Counter and prescaler sit at reload outside the counting state
  always_comb begin
    tick_d = unit_last;
    count_d = timeout_count_in;
    if (state_q == CWRC_WD_COUNT && state_d == CWRC_WD_COUNT) begin
      if (unit_done) begin
        tick_d = unit_last;
        count_d = count_q - COUNT_ONE;
      end else begin
        tick_d = tick_q - TICK_ONE;
        count_d = count_q;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= CWRC_WD_STOPPED;
      tick_q <= TICK_ZERO;
      count_q <= COUNT_ZERO;
    end else begin
      state_q <= state_d;
      tick_q <= tick_d;
      count_q <= count_d;
    end
  end

  // ----------------------------------------------------------------
  // Recovery load and lock
  // ----------------------------------------------------------------
  logic load_q;
  logic use_nm_q;
  logic use_nm_d;

  wire locked = state_q == CWRC_WD_LOCKED;
  // Source is caught at expiry so later writes cannot change it mid-load
  assign use_nm_d = expire ? recovery_source_select_in : use_nm_q;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      load_q <= 1'b0;
      use_nm_q <= 1'b0;
    end else begin
      load_q <= expire;
      use_nm_q <= use_nm_d;
    end
  end

  assign recovery_load_out = load_q;
  assign recovery_use_nm_out = use_nm_q;
  assign recovery_mode_out = locked;
  assign freq_write_accept_out = freq_write_in & ~locked;

  // ----------------------------------------------------------------
  // System reset
  // ----------------------------------------------------------------
  wire rst_by_timeout = expire & rst_timeout_en_q;
  wire rst_by_change = freq_change_in & rst_freq_en_q;
  wire rst_trigger = rst_by_timeout | rst_by_change;

  cwrc_pulse #(
    .PULSE_CYCLES(PULSE_CYCLES)
  ) u_pulse (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .trigger_in(rst_trigger),
    .pulse_out(sys_reset_out)
  );

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [7:0] control_view;
  logic [7:0] identity_view;

  always_comb begin
    control_view = CWRC_READ_ZERO;
    control_view[CWRC_BIT_PCI_DRIVE] = pci_drive_q;
    control_view[CWRC_BIT_RST_TIMEOUT] = rst_timeout_en_q;
    control_view[CWRC_BIT_RST_FREQ] = rst_freq_en_q;
    control_view[CWRC_BIT_TIMEOUT_FLAG] = flag_q;
    control_view[CWRC_BIT_RUN] = run_q;
  end

  // Identity is constant, so host writes to it have nothing to change
  always_comb begin
    identity_view = CWRC_READ_ZERO;
    identity_view[CWRC_REV_LSB +: CWRC_CODE_WIDTH] = REV_CODE;
    identity_view[0 +: CWRC_CODE_WIDTH] = MAKER_CODE;
  end

  wire [7:0] read_mux = hit_identity ? identity_view :
                        (hit_control ? control_view : CWRC_READ_ZERO);
  assign rdata_d = reg_rd_in ? read_mux : rdata_q;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_q <= CWRC_READ_ZERO;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_out = rdata_q;
  assign pci_drive_boost_out = pci_drive_q;

endmodule : cwrc_top

// >>> dv/cwrc_far_model.sv
// Frequency synthesizer and system reset receiver beside the block
`timescale 1ns/1ps
module cwrc_far_model (
  input wire logic clk_sys_in,
  input wire logic accept_in,
  input wire logic rst_pulse_in,
  output logic chg_out,
  output int pulses_out,
  output int width_out
);
  logic pend_q = 1'b0;
  int run = 0;
  initial chg_out = 1'b0;
  initial pulses_out = 0;
  initial width_out = 0;
  // ----------------------------------------------------------------
  // Accepted frequency byte retunes the outputs a cycle later
  // ----------------------------------------------------------------
  always @(posedge clk_sys_in) pend_q <= accept_in;
  always @(negedge clk_sys_in) chg_out <= pend_q;
  // Width is only known once the pulse has ended
  always @(posedge clk_sys_in) begin
    if (rst_pulse_in) begin
      run <= run + 1;
    end else if (run != 0) begin
      width_out <= run;
      pulses_out <= pulses_out + 1;
      run <= 0;
    end
  end
endmodule : cwrc_far_model

// >>> dv/cwrc_top_asserts.sv
// Port checker for the watchdog and reset control block
`timescale 1ns/1ps
module cwrc_top_asserts
  import cwrc_pkg::*;
#(
  parameter int PULSE_CYCLES = 16,
  parameter logic [3:0] REV_CODE = 4'h3, // Arbitrary value
  parameter logic [3:0] MAKER_CODE = 4'h5 // Arbitrary value
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic freq_write_in,
  input wire logic freq_write_accept_out,
  input wire logic recovery_load_out,
  input wire logic recovery_mode_out,
  input wire logic pci_drive_boost_out,
  input wire logic sys_reset_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  wire logic ctl_rd = reg_rd_in && reg_addr_in == CWRC_ADDR_CONTROL;
  wire logic unlock = reg_wr_in && reg_addr_in == CWRC_ADDR_CONTROL && !reg_wdata_in[CWRC_BIT_RUN];
  logic [8:0] hi_q;
  // Counter instead of a repetition, the pulse length is a parameter
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) hi_q <= 9'h000;
    else hi_q <= sys_reset_out ? hi_q + 9'h001 : 9'h000;
  end
  sequence load_s;
    recovery_load_out ##1 !recovery_load_out;
  endsequence
  accept_gate_a: assert property (freq_write_accept_out == (freq_write_in && !recovery_mode_out))
    else $error("frequency write gate wrong");
  ident_read_a: assert property (reg_rd_in && reg_addr_in == CWRC_ADDR_IDENTITY |=>
    reg_rdata_out == {REV_CODE, MAKER_CODE}) else $error("identity byte wrong");
  reserved_zero_a: assert property (ctl_rd |=> (reg_rdata_out & 8'hA1) == 8'h00)
    else $error("reserved control bits set");
  drive_read_a: assert property (ctl_rd && !reg_wr_in |=>
    reg_rdata_out[CWRC_BIT_PCI_DRIVE] == pci_drive_boost_out) else $error("drive bit and output differ");
  pulse_long_a: assert property (sys_reset_out |-> hi_q < PULSE_CYCLES)
    else $error("reset pulse too long");
  pulse_end_a: assert property ($fell(sys_reset_out) |-> hi_q == PULSE_CYCLES)
    else $error("reset pulse too short");
  load_once_a: assert property ($rose(recovery_mode_out) |-> load_s)
    else $error("recovery load missing");
  load_mode_a: assert property (recovery_load_out |-> recovery_mode_out)
    else $error("load outside recovery mode");
  run_unlock_a: assert property (recovery_mode_out && unlock |=> !recovery_mode_out)
    else $error("recovery mode not released");
  lock_hold_a: assert property (recovery_mode_out && !unlock |=> recovery_mode_out)
    else $error("recovery mode dropped");
endmodule : cwrc_top_asserts
bind cwrc_top cwrc_top_asserts #(.PULSE_CYCLES(PULSE_CYCLES), .REV_CODE(REV_CODE), .MAKER_CODE(MAKER_CODE)) i_chk (
  .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
  .reg_wdata_in(reg_wdata_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .freq_write_in(freq_write_in), .freq_write_accept_out(freq_write_accept_out),
  .recovery_load_out(recovery_load_out), .recovery_mode_out(recovery_mode_out),
  .pci_drive_boost_out(pci_drive_boost_out), .sys_reset_out(sys_reset_out));

// >>> dv/tb_cwrc_top.sv
// Self-checking bench for the watchdog and reset control block
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin miscompares++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, s); end end
module tb_cwrc_top;
  import cwrc_pkg::*;
  localparam int PULSE = 4;
  localparam int SHORT = 4;
  localparam int LONG = 8;
  localparam logic [7:0] ID = 8'hA6; // Arbitrary codes
  logic clk_sys_in = 1'b0, rst_n_in = 1'b0, wr_s = 1'b0, rd_s = 1'b0, fwr = 1'b0;
  logic pre_s = 1'b0, src_s = 1'b0, chg, load, nm, mode, pci, srst, acc;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [4:0] tmo = 5'h01;
  int miscompares = 0, checks_done = 0, ctrl = 0, flag = 0, seed = 36555;
  int pulses, width, n, cnt, u, p0;
  always #12.5 clk_sys_in = ~clk_sys_in;
  cwrc_top #(.SHORT_CYCLES(SHORT), .LONG_CYCLES(LONG), .PULSE_CYCLES(PULSE), .REV_CODE(ID[7:4]),
    .MAKER_CODE(ID[3:0])) i_cwrc_top (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .reg_addr_in(addr),
    .reg_wr_in(wr_s), .reg_wdata_in(wdata), .reg_rd_in(rd_s), .reg_rdata_out(rdata), .timeout_count_in(tmo),
    .prescale_long_in(pre_s), .recovery_source_select_in(src_s), .freq_write_in(fwr), .freq_change_in(chg),
    .freq_write_accept_out(acc), .recovery_load_out(load), .recovery_use_nm_out(nm),
    .recovery_mode_out(mode), .pci_drive_boost_out(pci), .sys_reset_out(srst));
  cwrc_far_model i_cwrc_far_model (.clk_sys_in(clk_sys_in), .accept_in(acc), .rst_pulse_in(srst),
    .chg_out(chg), .pulses_out(pulses), .width_out(width));
  // ----------------------------------------------------------------
  // Bus tasks and the control byte model
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_in);
    addr = a;
    wdata = d;
    wr_s = 1'b1;
    @(negedge clk_sys_in);
    wr_s = 1'b0;
    if (a == CWRC_ADDR_CONTROL) begin
      ctrl = d & 8'h5A;
      if (d[CWRC_BIT_TIMEOUT_FLAG]) flag = 0;
    end
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_sys_in);
    addr = a;
    rd_s = 1'b1;
    @(negedge clk_sys_in);
    rd_s = 1'b0;
    `CHK("rdata", e, rdata)
  endtask : rd
  task automatic fw();
    @(negedge clk_sys_in);
    fwr = 1'b1;
    @(negedge clk_sys_in);
    fwr = 1'b0;
  endtask : fw
  function automatic logic [7:0] ctl();
    return 8'(ctrl | (flag << 2));
  endfunction : ctl
  task automatic report_and_stop();
    if (miscompares == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  // Whole run is well under a thousand cycles
  initial begin
    #100us;
    miscompares++;
    report_and_stop();
  end
  initial begin
    repeat (3) @(negedge clk_sys_in);
    rst_n_in = 1'b1;
    rd(CWRC_ADDR_IDENTITY, ID);
    rd(CWRC_ADDR_CONTROL, 8'h00);
    rd(8'h10 | 8'($random(seed)), 8'h00);
    wr(CWRC_ADDR_IDENTITY, 8'($random(seed)));
    rd(CWRC_ADDR_IDENTITY, ID);
    wr(CWRC_ADDR_CONTROL, 8'hFF);
    `CHK("pci", 1'b1, pci)
    rd(CWRC_ADDR_CONTROL, ctl());
    for (int b = 0; b < 2; b++) begin
      wr(CWRC_ADDR_CONTROL, b ? 8'h08 : 8'h00);
      p0 = pulses;
      fw();
      repeat (PULSE + 4) @(negedge clk_sys_in);
      `CHK("fc_pulses", p0 + b, pulses)
    end
    `CHK("width", PULSE, width)
    wr(CWRC_ADDR_CONTROL, 8'h02);
    fw();
    repeat (2) @(negedge clk_sys_in);
    wr(CWRC_ADDR_CONTROL, 8'h00);
    repeat (60) @(negedge clk_sys_in);
    `CHK("stopped", 1'b0, mode)
    for (int r = 0; r < 2; r++) begin
      cnt = 1 + (($random(seed) & 32'hFF) % 3);
      tmo = 5'(cnt);
      // Both prescaler units and both recovery sources get one pass each
      pre_s = 1'(r);
      src_s = ~pre_s;
      u = pre_s ? LONG : SHORT;
      p0 = pulses;
      wr(CWRC_ADDR_CONTROL, r ? 8'h12 : 8'h02);
      repeat (40) @(negedge clk_sys_in);
      `CHK("early", 1'b0, mode)
      fw();
      n = 0;
      while (mode !== 1'b1 && n < 300) begin
        @(negedge clk_sys_in);
        n++;
      end
      `CHK("expiry", 1'b1, n >= cnt * u && n <= cnt * u + 6)
      flag = 1;
      repeat (PULSE + 2) @(negedge clk_sys_in);
      `CHK("use_nm", src_s, nm)
      `CHK("to_pulses", p0 + r, pulses)
      fw();
      wr(CWRC_ADDR_CONTROL, r ? 8'h12 : 8'h02);
      `CHK("locked", 1'b1, mode)
      rd(CWRC_ADDR_CONTROL, ctl());
      wr(CWRC_ADDR_CONTROL, 8'h04);
      `CHK("released", 1'b0, mode)
      rd(CWRC_ADDR_CONTROL, ctl());
    end
    report_and_stop();
  end
endmodule : tb_cwrc_top
